// ---- src/rtps_dev.sv ----
// What this block and the baseband model do
// [RQ1] Raise request; baseband grants for data bits
// [RQ2] Baseband holds grant until last symbol
// [RQ3] Every field sent least significant bit first
// [RQ4] Change data on strobe rising edge
// [RQ5] Request idle at least 2.22 us
// [RQ6] Drop request quickly after last strobe
// [RQ7] Baseband stops strobe when request falls
// [RQ8] Baseband modulates 2 us past last chip
// [RQ9] Select, switch, request, amplifier start order
// [RQ10] Switch at 2 us, amplifier 3 us
// [RQ11] Antenna switch driven as complementary pair
// [RQ12] Drop request right after final bit
// [RQ13] Wait grant low, then amp, switch, select
// [RQ14] Amplifier 3 us, switch 2 us before select
// [RQ15] Select encodings for power states
// [RQ16] Only second select toggles in operation
// [RQ17] Synth on when enable and any select
// [RQ18] Programmable request delay between switch, amp
module rtps_dev
	import rtps_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int REQ_DELAY = REQ_DELAY_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// User data stream
	input wire logic i_data_valid,
	output logic o_data_ready,
	input wire logic [WIDTH-1:0] i_data,
	input wire logic i_data_last,
	// Front-end mode when not sending
	input wire logic i_power_on,
	// Status
	output logic o_busy,
	// Link
	rtps_if.dev link
);

	// Sequencer state
	rtps_state_e state_r;
	logic [CNT_W-1:0] cnt_r;
	// Input synchronisers for strobe and grant
	logic [1:0] stb_sync_r;
	logic [1:0] gnt_sync_r;
	logic stb_prev_r;
	logic stb_rise;
	// Shift register and bit count
	logic [WIDTH-1:0] shift_r;
	logic [$clog2(WIDTH+1)-1:0] bits_r;
	logic last_word_r;
	// FIFO read side
	logic f_valid;
	logic f_ready;
	logic [WIDTH-1:0] f_data;
	logic f_last;
	// Output registers
	logic req_r;
	logic txd_r;
	logic psel_b_r;
	logic sw_tx_r;
	logic pa_r;

	// Buffer for data words with end marker
	rtps_fifo #(.WIDTH(WIDTH + 1), .DEPTH(DEPTH)) u_fifo (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_in_valid(i_data_valid),
		.o_in_ready(o_data_ready),
		.i_in_data({i_data_last, i_data}),
		.o_out_valid(f_valid),
		.i_out_ready(f_ready),
		.o_out_data({f_last, f_data})
	);

	// Two-flop synchronisers on the link inputs
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			stb_sync_r <= 2'h0;
			gnt_sync_r <= 2'h0;
			stb_prev_r <= 1'b0;
		end else begin
			stb_sync_r <= {stb_sync_r[0], link.tx_bit_strobe};
			gnt_sync_r <= {gnt_sync_r[0], link.bbp_tx_grant};
			stb_prev_r <= stb_sync_r[1];
		end
	end

	// Strobe rising edge, only counted while granted and requesting
	assign stb_rise = stb_sync_r[1] && !stb_prev_r && gnt_sync_r[1] && req_r;
	// Load a new word when the shifter runs dry
	assign f_ready = (state_r == RTPS_SEND) && stb_rise && (bits_r == '0) && !last_word_r;

	// Sequencer state and timer
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r <= RTPS_IDLE;
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			unique case (state_r)
				RTPS_IDLE: begin
					// Start once a word is waiting
					if (f_valid) begin
						state_r <= RTPS_RAMP;
						cnt_r <= '0;
					end
				end
				RTPS_RAMP: begin
					if (cnt_r == CNT_W'(PA_DELAY_CYC - 1)) begin
						state_r <= RTPS_SEND;
					end
				end
				RTPS_SEND: begin
					// Request drops after final bit
					// Timer wraps while sending, so only the drop decides
					if (!req_r) begin
						state_r <= RTPS_DRAIN;
					end
				end
				RTPS_DRAIN: begin
					// [RQ13] wait grant low
					if (!gnt_sync_r[1]) begin
						state_r <= RTPS_PADN;
						cnt_r <= '0;
					end
				end
				RTPS_PADN: begin
					// [RQ14] switch 1 us after amp off
					if (cnt_r == CNT_W'(PA_DELAY_CYC - SW_DELAY_CYC - 1)) begin
						state_r <= RTPS_SWRX;
						cnt_r <= '0;
					end
				end
				RTPS_SWRX: begin
					// [RQ14] select 2 us after switch
					if (cnt_r == CNT_W'(SW_DELAY_CYC - 1)) begin
						state_r <= RTPS_GAP;
						cnt_r <= '0;
					end
				end
				RTPS_GAP: begin
					// [RQ5] request idle time
					if (cnt_r >= CNT_W'(REQ_IDLE_CYC - 1)) begin
						state_r <= RTPS_IDLE;
					end
				end
			endcase
		end
	end

	// Front-end controls follow the state and timer
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			psel_b_r <= 1'b1;
			sw_tx_r <= 1'b0;
			pa_r <= 1'b0;
		end else begin
			// [RQ9] select moves first
			psel_b_r <= !(state_r == RTPS_RAMP || state_r == RTPS_SEND
				|| state_r == RTPS_DRAIN || state_r == RTPS_PADN || state_r == RTPS_SWRX);
			// [RQ10] switch at 2 us
			if (state_r == RTPS_RAMP && cnt_r == CNT_W'(SW_DELAY_CYC - 1)) begin
				sw_tx_r <= 1'b1;
			end else if (state_r == RTPS_SWRX) begin
				sw_tx_r <= 1'b0;
			end
			// [RQ10] amplifier at 3 us
			if (state_r == RTPS_RAMP && cnt_r == CNT_W'(PA_DELAY_CYC - 1)) begin
				pa_r <= 1'b1;
			end else if (state_r == RTPS_PADN || state_r == RTPS_IDLE) begin
				pa_r <= 1'b0;
			end
		end
	end

	// Baseband request and serial data path
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			req_r <= 1'b0;
			txd_r <= 1'b0;
			shift_r <= '0;
			bits_r <= '0;
			last_word_r <= 1'b0;
		end else begin
			// [RQ18] programmable request delay
			if (state_r == RTPS_RAMP && cnt_r == CNT_W'(REQ_DELAY - 1)) begin
				req_r <= 1'b1;
				last_word_r <= 1'b0;
				bits_r <= '0;
			end
			if (stb_rise && state_r == RTPS_SEND) begin
				if (bits_r == '0) begin
					if (last_word_r) begin
						// [RQ12] drop after final bit
						req_r <= 1'b0;
					end else begin
						// [RQ3] low bit first
						txd_r <= f_data[0];
						shift_r <= f_data >> 1;
						bits_r <= ($bits(bits_r))'(WIDTH - 1);
						last_word_r <= f_last;
					end
				end else begin
					// [RQ4] change on strobe rise
					txd_r <= shift_r[0];
					shift_r <= shift_r >> 1;
					bits_r <= bits_r - 1'b1;
				end
			end
		end
	end

	// [RQ6] quick request drop
	assign link.bbp_tx_request = req_r;
	assign link.tx_data = txd_r;
	// [RQ15] first select static, high while i_power_on
	assign link.radio_power_sel_a = i_power_on;
	// [RQ16] only second select toggles
	assign link.radio_power_sel_b = psel_b_r & i_power_on;
	// [RQ11] complementary switch pair
	assign link.antenna_switch_pos = sw_tx_r;
	assign link.antenna_switch_neg = !sw_tx_r;
	assign link.amplifier_enable = pa_r;
	assign o_busy = (state_r != RTPS_IDLE);
endmodule

// ---- include/rtps_pkg.sv ----
package rtps_pkg;
	// Master clock period in ns
	localparam int CLK_PERIOD_NS = 20;
	// Front-end delays in ns
	localparam int SW_DELAY_NS = 2000;
	localparam int PA_DELAY_NS = 3000;
	// Least idle time of the transmit request in ns (2.22 us)
	localparam int REQ_IDLE_NS = 2220;
	// Cycle counts derived from the times
	localparam int SW_DELAY_CYC = SW_DELAY_NS / CLK_PERIOD_NS;
	localparam int PA_DELAY_CYC = PA_DELAY_NS / CLK_PERIOD_NS;
	localparam int REQ_IDLE_CYC = (REQ_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Default request delay after select change (between switch and amplifier)
	localparam int REQ_DELAY_CYC = 125;
	// Counter width
	localparam int CNT_W = 8;
	// Power select encodings {a,b}
	localparam logic [1:0] PSEL_DOWN = 2'h0;
	localparam logic [1:0] PSEL_RX = 2'h3;
	localparam logic [1:0] PSEL_TX = 2'h2;
	localparam logic [1:0] PSEL_SYNTH = 2'h1;
	// Baseband preamble/header build time, in cycles
	localparam int BB_HDR_CYC = 40;
	// Baseband strobe half period in cycles (160 ns period)
	localparam int BB_HALF_CYC = 4;
	// Modulation extension after last chip, 2 us
	localparam int BB_EXT_CYC = 2000 / CLK_PERIOD_NS;
	// Sequencer states
	typedef enum logic [2:0] {
		RTPS_IDLE, RTPS_RAMP, RTPS_SEND, RTPS_DRAIN, RTPS_PADN, RTPS_SWRX, RTPS_GAP
	} rtps_state_e;
	// Baseband states
	typedef enum logic [1:0] {BB_IDLE, BB_HDR, BB_DATA, BB_EXT} rtps_bb_e;
endpackage

// ---- include/rtps_if.sv ----
interface rtps_if;
	logic bbp_tx_request;
	logic bbp_tx_grant;
	logic tx_bit_strobe;
	logic tx_data;
	logic radio_power_sel_a;
	logic radio_power_sel_b;
	logic antenna_switch_pos;
	logic antenna_switch_neg;
	logic amplifier_enable;
	// Device (MAC) end
	modport dev (
		output bbp_tx_request, tx_data, radio_power_sel_a, radio_power_sel_b,
		output antenna_switch_pos, antenna_switch_neg, amplifier_enable,
		input bbp_tx_grant, tx_bit_strobe
	);
	// Baseband and front-end end
	modport bb (
		input bbp_tx_request, tx_data, radio_power_sel_a, radio_power_sel_b,
		input antenna_switch_pos, antenna_switch_neg, amplifier_enable,
		output bbp_tx_grant, tx_bit_strobe
	);
endinterface

// ---- src/rtps_fifo.sv ----
module rtps_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Write side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// Read side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	// Storage array
	logic [WIDTH-1:0] mem_r [DEPTH];
	// Pointers with wrap bit
	logic [AW:0] wptr_r;
	logic [AW:0] rptr_r;
	logic full;
	logic empty;
	logic push;
	logic pop;

	// Flags from pointers
	assign empty = (wptr_r == rptr_r);
	assign full = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
	assign o_in_ready = !full;
	assign o_out_valid = !empty;
	assign push = i_in_valid && !full;
	assign pop = i_out_ready && !empty;
	assign o_out_data = mem_r[rptr_r[AW-1:0]];

	// Storage write
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_r[wptr_r[AW-1:0]] <= i_in_data;
		end
	end

	// Write pointer
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wptr_r <= '0;
		end else if (push) begin
			wptr_r <= wptr_r + 1'b1;
		end
	end

	// Read pointer
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rptr_r <= '0;
		end else if (pop) begin
			rptr_r <= rptr_r + 1'b1;
		end
	end
endmodule

// ---- src/rtps_bb.sv ----
module rtps_bb
	import rtps_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Synthesizer enable from serial control
	input wire logic i_synth_enable,
	// Received stream and status
	output logic o_bit_valid,
	output logic o_bit,
	output logic o_synth_on,
	output logic o_modulating,
	// Link
	rtps_if.bb link
);
	rtps_bb_e state_r;
	logic [7:0] cnt_r;
	logic [1:0] req_sync_r;
	logic strobe_r;
	logic grant_r;
	logic bit_valid_r;
	logic bit_r;
	// Set once the first strobe rise has launched bit 0
	logic primed_r;

	// Request synchroniser
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			req_sync_r <= 2'h0;
		end else begin
			req_sync_r <= {req_sync_r[0], link.bbp_tx_request};
		end
	end

	// Header, data and ramp-down sequence
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r <= BB_IDLE;
			cnt_r <= '0;
			strobe_r <= 1'b0;
			grant_r <= 1'b0;
			bit_valid_r <= 1'b0;
			bit_r <= 1'b0;
			primed_r <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			bit_valid_r <= 1'b0;
			unique case (state_r)
				BB_IDLE: begin
					cnt_r <= '0;
					primed_r <= 1'b0;
					// [RQ1] request starts a packet
					if (req_sync_r[1]) begin
						state_r <= BB_HDR;
					end
				end
				BB_HDR: begin
					// [RQ1] grant after header
					if (cnt_r == 8'(BB_HDR_CYC)) begin
						grant_r <= 1'b1;
						state_r <= BB_DATA;
						cnt_r <= '0;
					end
				end
				BB_DATA: begin
					if (cnt_r == 8'(BB_HALF_CYC - 1)) begin
						cnt_r <= '0;
						strobe_r <= !strobe_r;
						// Sample data on the rising strobe
						if (!strobe_r) begin
							// First rise only makes the far end put out bit 0
							primed_r <= 1'b1;
							bit_valid_r <= primed_r;
							bit_r <= link.tx_data;
						end
					end
					// [RQ7] stop strobe when request falls
					if (!req_sync_r[1]) begin
						strobe_r <= 1'b0;
						state_r <= BB_EXT;
						cnt_r <= '0;
					end
				end
				BB_EXT: begin
					// [RQ2] grant held through final symbol
					if (cnt_r == 8'(BB_HALF_CYC * 2)) begin
						grant_r <= 1'b0;
					end
					// [RQ8] modulate 2 us more
					// Tail counted from the grant drop, the last chip
					if (cnt_r == 8'(BB_HALF_CYC * 2 + BB_EXT_CYC)) begin
						state_r <= BB_IDLE;
					end
				end
			endcase
		end
	end

	assign link.tx_bit_strobe = strobe_r;
	assign link.bbp_tx_grant = grant_r;
	assign o_bit_valid = bit_valid_r;
	assign o_bit = bit_r;
	assign o_modulating = (state_r != BB_IDLE);
	// [RQ17] synthesizer on when enable and either select is high
	assign o_synth_on = i_synth_enable && (link.radio_power_sel_a || link.radio_power_sel_b);
endmodule

// ---- sim/rtps_props.sv ----
module rtps_props
	import rtps_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Link lines
	input wire logic bbp_tx_request,
	input wire logic bbp_tx_grant,
	input wire logic tx_bit_strobe,
	input wire logic tx_data,
	input wire logic radio_power_sel_a,
	input wire logic radio_power_sel_b,
	input wire logic antenna_switch_pos,
	input wire logic antenna_switch_neg,
	input wire logic amplifier_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	// Cycles the request has stayed low
	logic [7:0] low_cnt_r;
	// Saturating idle counter
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			low_cnt_r <= 8'hff;
		end else if (bbp_tx_request) begin
			low_cnt_r <= 8'h00;
		end else if (low_cnt_r != 8'hff) begin
			low_cnt_r <= low_cnt_r + 8'h01;
		end
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);
	// Leaving receive mode for transmit
	sequence s_start;
		$fell(radio_power_sel_b) && radio_power_sel_a;
	endsequence
	// Amplifier turned off
	sequence s_pa_off;
		$fell(amplifier_enable);
	endsequence
	property p_sw_pair;
		antenna_switch_neg != antenna_switch_pos;
	endproperty
	a_sw_pair: assert property (p_sw_pair) else $error("switch pair");
	property p_sw_on;
		s_start |-> ##[95:105] $rose(antenna_switch_pos);
	endproperty
	a_sw_on: assert property (p_sw_on) else $error("switch delay");
	property p_pa_on;
		s_start |-> ##[145:155] $rose(amplifier_enable);
	endproperty
	a_pa_on: assert property (p_pa_on) else $error("amp delay");
	property p_req_order;
		$rose(bbp_tx_request) |-> antenna_switch_pos && !amplifier_enable && !radio_power_sel_b;
	endproperty
	a_req_order: assert property (p_req_order) else $error("request order");
	property p_req_idle;
		$rose(bbp_tx_request) |-> low_cnt_r >= 8'(REQ_IDLE_CYC);
	endproperty
	a_req_idle: assert property (p_req_idle) else $error("request gap");
	property p_pa_cause;
		s_pa_off |-> !bbp_tx_grant && !bbp_tx_request;
	endproperty
	a_pa_cause: assert property (p_pa_cause) else $error("amp off early");
	property p_sw_off;
		s_pa_off |-> ##[45:55] $fell(antenna_switch_pos);
	endproperty
	a_sw_off: assert property (p_sw_off) else $error("switch back");
	property p_sel_back;
		s_pa_off |-> ##[145:155] $rose(radio_power_sel_b);
	endproperty
	a_sel_back: assert property (p_sel_back) else $error("select back");
	property p_setup;
		$rose(tx_bit_strobe) |-> $stable(tx_data);
	endproperty
	a_setup: assert property (p_setup) else $error("data at strobe");
	property p_grant_hold;
		$fell(bbp_tx_request) |-> bbp_tx_grant && tx_bit_strobe;
	endproperty
	a_grant_hold: assert property (p_grant_hold) else $error("request drop");
	// No strobe rises while the request is low
	property p_strobe_stop;
		!bbp_tx_request |-> !$rose(tx_bit_strobe);
	endproperty
	a_strobe_stop: assert property (p_strobe_stop) else $error("strobe after request");
endmodule

// ---- sim/tb_top.sv ----
module tb_top
	import rtps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Stimulus
	logic i_clk, i_rstn, i_data_valid, i_data_last, i_power_on, i_synth_enable;
	logic [7:0] i_data;
	// Design outputs
	logic o_data_ready, o_busy, o_bit_valid, o_bit, o_synth_on, o_modulating;
	// Counters and monitors
	int bad_count, total_checks, gap, low_n, ext, mod_n;
	logic exp_q[$];
	logic got_q[$];
	rtps_if lnk();
	rtps_dev #(.WIDTH(8), .DEPTH(16), .REQ_DELAY(REQ_DELAY_CYC)) u_rtps_dev (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_data_valid(i_data_valid),
		.o_data_ready(o_data_ready), .i_data(i_data), .i_data_last(i_data_last),
		.i_power_on(i_power_on), .o_busy(o_busy), .link(lnk.dev));
	rtps_bb #(.WIDTH(8)) u_rtps_bb (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_synth_enable(i_synth_enable),
		.o_bit_valid(o_bit_valid), .o_bit(o_bit), .o_synth_on(o_synth_on),
		.o_modulating(o_modulating), .link(lnk.bb));
	rtps_props u_rtps_props (
		.i_clk(i_clk), .i_rstn(i_rstn), .bbp_tx_request(lnk.bbp_tx_request),
		.bbp_tx_grant(lnk.bbp_tx_grant), .tx_bit_strobe(lnk.tx_bit_strobe),
		.tx_data(lnk.tx_data), .radio_power_sel_a(lnk.radio_power_sel_a),
		.radio_power_sel_b(lnk.radio_power_sel_b),
		.antenna_switch_pos(lnk.antenna_switch_pos),
		.antenna_switch_neg(lnk.antenna_switch_neg),
		.amplifier_enable(lnk.amplifier_enable));
	// 50 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	// Bits seen, request gap, modulation tail
	always @(posedge i_clk) begin
		if (o_bit_valid === 1'b1) begin
			got_q.push_back(o_bit);
		end
		if (lnk.bbp_tx_request === 1'b1) begin
			gap = (low_n > 0) ? low_n : gap;
			low_n = 0;
		end else begin
			low_n++;
		end
		if (lnk.bbp_tx_grant === 1'b1) begin
			mod_n = 0;
		end else if (o_modulating === 1'b1) begin
			mod_n++;
			ext = mod_n;
		end
	end
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	// Print verdict and stop
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Write one packet of n words, noting any refusal
	task automatic send(input int n, input logic [7:0] seed, output logic full);
		logic [7:0] d;
		int w;
		full = 1'b0;
		for (int i = 0; i < n; i++) begin
			d = seed + 8'(i * 8'h35);
			i_data_valid <= 1'b1;
			i_data <= d;
			i_data_last <= (i == n - 1);
			w = 0;
			do begin
				@(posedge i_clk);
				w++;
				full = full | (o_data_ready !== 1'b1);
			end while (o_data_ready !== 1'b1 && w < 5000);
			// A write that never lands counts against the run
			if (o_data_ready !== 1'b1) begin
				bad_count++;
			end
			for (int b = 0; b < 8; b++) begin
				exp_q.push_back(d[b]);
			end
		end
		// One edge passes so a following call never re-raises valid in this step
		i_data_valid <= 1'b0;
		@(posedge i_clk);
	endtask
	// Wait for a quiet link, then compare the bit stream
	task automatic finish_pkt();
		int q;
		int w;
		q = 0;
		w = 0;
		while (q < 300 && w < 30000) begin
			@(posedge i_clk);
			w++;
			q = (o_busy === 1'b0 && o_modulating === 1'b0) ? q + 1 : 0;
		end
		// A link that never goes quiet counts against the run
		if (q < 300) begin
			bad_count++;
		end
		chk("bit count", got_q.size(), exp_q.size());
		for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
			chk("bit", got_q[i], exp_q[i]);
		end
		exp_q.delete();
		got_q.delete();
	endtask
	// Idle link after reset
	task automatic t_reset();
		chk("idle link", {lnk.bbp_tx_request, lnk.antenna_switch_pos, lnk.antenna_switch_neg,
			lnk.amplifier_enable, lnk.radio_power_sel_a, lnk.radio_power_sel_b,
			lnk.bbp_tx_grant}, 7'h16);
	endtask
	// Two packets queued back to back
	task automatic t_packets();
		logic full;
		send(2, 8'ha5, full);
		send(1, 8'h3c, full);
		finish_pkt();
		chk("request gap ok", 32'(gap >= REQ_IDLE_CYC), 1);
		chk("tail ok", 32'(ext >= BB_EXT_CYC), 1);
	endtask
	// Fill the buffer past its depth
	task automatic t_fill();
		logic full;
		send(20, 8'h01, full);
		chk("buffer refused", full, 1);
		finish_pkt();
	endtask
	// Power select modes and synthesizer gating
	task automatic t_power();
		for (int i = 0; i < 4; i++) begin
			i_power_on <= i[1];
			i_synth_enable <= i[0];
			repeat (4) @(posedge i_clk);
			chk("selects", {lnk.radio_power_sel_a, lnk.radio_power_sel_b}, {2{i[1]}});
			chk("synth", o_synth_on, i[0] & i[1]);
		end
	endtask
	initial begin
		i_rstn = 1'b0;
		i_data_valid = 1'b0;
		i_data = 8'h00;
		i_data_last = 1'b0;
		i_power_on = 1'b1;
		i_synth_enable = 1'b1;
		repeat (20) @(posedge i_clk);
		i_rstn <= 1'b1;
		@(posedge i_clk);
		t_reset();
		t_packets();
		t_fill();
		t_power();
		results();
	end
	// Watchdog
	initial begin
		repeat (40000) @(posedge i_clk);
		bad_count++;
		results();
	end
endmodule
